// >>> rtl/cieu_pkg.sv
// constants and types of the interrupt and exception front end
//
// Function
// - request lines are active-high level requests
// - lines 11, 7, 3: external, timer, software
// - lines 31..16 custom, upper enable/pending bits
// - one-cycle acknowledge pulse, index valid then
// - every interrupt disabled after reset
// - take only with global and line enable
// - priority 31..16, then 11, 3, 7
// - debug mode ignores all interrupt requests
// - causes 2 illegal, 3 breakpoint, 11 ecall
// - illegal and ecall exceptions never disabled
// - undefined encodings illegal unless configured custom; only the major opcode is decoded, except for system words
// - no float unit: float instructions illegal
// - no custom extension: custom instructions illegal
// - trap saves pc and global enable copy
// - vectored interrupts to base plus four times index
// - trap entry clears global interrupt enable
// - return resumes saved pc, restores enable
package cieu_pkg;

  // ==========================================================
  // register map (byte addresses on the bus)
  localparam logic [11:0] OFS_STATUS  = 12'h000;
  localparam logic [11:0] OFS_ENABLE  = 12'h004;
  localparam logic [11:0] OFS_PENDING = 12'h008;
  localparam logic [11:0] OFS_VECTOR  = 12'h00C;
  localparam logic [11:0] OFS_RETADDR = 12'h010;
  localparam logic [11:0] OFS_CAUSE   = 12'h014;

  // ==========================================================
  // fields
  localparam int          STATUS_GIE_BIT   = 3;
  localparam int          STATUS_PGIE_BIT  = 7;
  localparam logic [31:0] IRQ_IMPL_MASK    = 32'hFFFF0888;
  localparam int          IRQ_EXT_IDX      = 11;
  localparam int          IRQ_SW_IDX       = 3;
  localparam int          IRQ_TIMER_IDX    = 7;
  localparam int          IRQ_CUSTOM_LO    = 16;
  localparam logic [1:0]  VEC_MODE_VECTOR  = 2'h1;
  localparam int          VEC_BASE_LSB     = 8;
  localparam logic [4:0]  CAUSE_ILLEGAL    = 5'h02;
  localparam logic [4:0]  CAUSE_BREAK      = 5'h03;
  localparam logic [4:0]  CAUSE_ECALL_M    = 5'h0B;

  // ==========================================================
  // reset values
  localparam logic [31:0] RST_ZERO         = 32'h00000000;

  // ==========================================================
  // instruction words and major opcodes
  localparam logic [31:0] INSN_ECALL       = 32'h00000073;
  localparam logic [31:0] INSN_EBREAK      = 32'h00100073;
  localparam logic [31:0] INSN_MRET        = 32'h30200073;
  localparam logic [6:0]  OPC_SYSTEM       = 7'h73;

  typedef enum logic [2:0] {
    CIEU_CLS_LEGAL   = 3'b000,
    CIEU_CLS_ILLEGAL = 3'b001,
    CIEU_CLS_ECALL   = 3'b010,
    CIEU_CLS_BREAK   = 3'b011,
    CIEU_CLS_MRET    = 3'b100
  } cieu_cls_t;

endpackage : cieu_pkg

// >>> rtl/cieu_top.sv
// interrupt and exception front end with APB control registers
`timescale 1ns/1ps
`default_nettype none
module cieu_top #(
  parameter bit FLOAT_UNIT_PRESENT = 1'b0,
  parameter bit CUSTOM_EXT_PRESENT = 1'b0
) (
  // clock and reset
  input  wire  logic        MCLK,
  input  wire  logic        RST,
  // apb slave
  input  wire  logic        PSEL,
  input  wire  logic        PENABLE,
  input  wire  logic        PWRITE,
  input  wire  logic [11:0] PADDR,
  input  wire  logic [31:0] PWDATA,
  output logic [31:0]       PRDATA,
  output logic              PREADY,
  output logic              PSLVERR,
  // interrupt requests and acknowledge
  input  wire  logic [31:0] IRQ,
  input  wire  logic        DEBUG_MODE,
  output logic              IRQ_ACK,
  output logic [4:0]        TAKEN_INTERRUPT_INDEX,
  // instruction at the commit point
  input  wire  logic        INSTR_VALID,
  input  wire  logic [31:0] INSTR,
  input  wire  logic [31:0] PC,
  // redirect to the fetch unit
  output logic              TRAP_TAKEN,
  output logic              MRET_TAKEN,
  output logic [31:0]       TRAP_CAUSE,
  output logic [31:0]       REDIRECT_ADDR
);
  import cieu_pkg::*;

  // ==========================================================
  // state
  logic        gie_ff;
  logic        pgie_ff;
  logic [31:0] enable_ff;
  logic [31:0] pending_ff;
  logic [31:0] vector_ff;
  logic [31:0] retaddr_ff;
  logic [31:0] cause_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        ack_ff;
  logic [4:0]  index_ff;
  logic        trap_ff;
  logic        mret_ff;
  logic [31:0] tcause_ff;
  logic [31:0] redirect_ff;

  logic [31:0] active;
  logic        irq_go;
  logic [4:0]  pick_idx;
  cieu_cls_t   cls;
  logic        exc_go;
  logic        mret_go;
  logic [4:0]  exc_code;
  logic [31:0] nxt_cause;
  logic [31:0] nxt_redirect;
  logic        wr_en;
  logic        setup;
  logic        addr_ok;

  // ==========================================================
  // instruction classification
  function automatic cieu_cls_t classify(input logic [31:0] w);
    cieu_cls_t r;
    r = CIEU_CLS_ILLEGAL;
    if (w[1:0] == 2'h3) begin
      case (w[6:0])
        7'h37, 7'h17, 7'h6F, 7'h67, 7'h63, 7'h03,
        7'h23, 7'h13, 7'h33, 7'h0F: r = CIEU_CLS_LEGAL;
        // float loads, stores, fused and arithmetic groups
        7'h07, 7'h27, 7'h43, 7'h47, 7'h4B, 7'h4F, 7'h53: begin
          r = FLOAT_UNIT_PRESENT ? CIEU_CLS_LEGAL
                                 : CIEU_CLS_ILLEGAL;
        end
        // custom opcode spaces
        7'h0B, 7'h2B, 7'h5B, 7'h7B: begin
          r = CUSTOM_EXT_PRESENT ? CIEU_CLS_LEGAL
                                 : CIEU_CLS_ILLEGAL;
        end
        OPC_SYSTEM: begin
          if (w == INSN_ECALL) begin
            r = CIEU_CLS_ECALL;
          end else if (w == INSN_EBREAK) begin
            r = CIEU_CLS_BREAK;
          end else if (w == INSN_MRET) begin
            r = CIEU_CLS_MRET;
          end else if (w[14:12] != 3'h0 && w[14:12] != 3'h4) begin
            r = CIEU_CLS_LEGAL;
          end else begin
            r = CIEU_CLS_ILLEGAL;
          end
        end
        default: r = CIEU_CLS_ILLEGAL;
      endcase
    end
    return r;
  endfunction : classify

  // ==========================================================
  // fixed priority pick
  function automatic logic [4:0] pick(input logic [31:0] a);
    logic [4:0] r;
    logic       hit;
    r   = 5'(IRQ_TIMER_IDX);
    hit = 1'b0;
    for (int i = 31; i >= IRQ_CUSTOM_LO; i--) begin
      if (a[i] && !hit) begin
        r   = 5'(i);
        hit = 1'b1;
      end
    end
    if (!hit && a[IRQ_EXT_IDX]) begin
      r   = 5'(IRQ_EXT_IDX);
      hit = 1'b1;
    end
    if (!hit && a[IRQ_SW_IDX]) begin
      r = 5'(IRQ_SW_IDX);
    end
    return r;
  endfunction : pick

  // ==========================================================
  // commit decision
  // interrupts win over the instruction, which is then not executed
  assign active   = pending_ff & enable_ff;
  assign irq_go   = gie_ff && (|active) && !DEBUG_MODE;
  assign pick_idx = pick(active);
  assign cls      = classify(INSTR);
  assign exc_go   = INSTR_VALID && !irq_go &&
                    (cls == CIEU_CLS_ILLEGAL || cls == CIEU_CLS_ECALL ||
                     cls == CIEU_CLS_BREAK);
  assign mret_go  = INSTR_VALID && !irq_go && cls == CIEU_CLS_MRET;

  always_comb begin
    case (cls)
      CIEU_CLS_ECALL: exc_code = CAUSE_ECALL_M;
      CIEU_CLS_BREAK: exc_code = CAUSE_BREAK;
      default:        exc_code = CAUSE_ILLEGAL;
    endcase
  end

  always_comb begin
    nxt_cause    = {27'h0000000, exc_code};
    nxt_redirect = {vector_ff[31:VEC_BASE_LSB], 8'h00};
    if (irq_go) begin
      nxt_cause = {1'b1, 26'h0000000, pick_idx};
      if (vector_ff[1:0] == VEC_MODE_VECTOR) begin
        nxt_redirect = {vector_ff[31:VEC_BASE_LSB], 1'b0,
                        pick_idx, 2'b00};
      end
    end else if (mret_go) begin
      nxt_redirect = retaddr_ff;
    end
  end

  // ==========================================================
  // apb decode
  // zero wait state: read data is latched in the setup cycle
  assign setup   = PSEL && !PENABLE;
  assign wr_en   = PSEL && PENABLE && PWRITE && addr_ok;
  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_ff;
  assign PSLVERR = pslverr_ff && PSEL && PENABLE;

  always_comb begin
    case (PADDR)
      OFS_STATUS, OFS_ENABLE, OFS_PENDING, OFS_VECTOR,
      OFS_RETADDR, OFS_CAUSE: addr_ok = 1'b1;
      default:                addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      prdata_ff  <= RST_ZERO;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      pslverr_ff <= !addr_ok;
      case (PADDR)
        OFS_STATUS: begin
          prdata_ff <= RST_ZERO;
          prdata_ff[STATUS_GIE_BIT]  <= gie_ff;
          prdata_ff[STATUS_PGIE_BIT] <= pgie_ff;
        end
        OFS_ENABLE:  prdata_ff <= enable_ff;
        OFS_PENDING: prdata_ff <= pending_ff;
        OFS_VECTOR:  prdata_ff <= vector_ff;
        OFS_RETADDR: prdata_ff <= retaddr_ff;
        OFS_CAUSE:   prdata_ff <= cause_ff;
        default:     prdata_ff <= RST_ZERO;
      endcase
    end
  end

  // ==========================================================
  // global enable and its saved copy
  // a trap in the same cycle as a software write wins
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      gie_ff  <= 1'b0;
      pgie_ff <= 1'b0;
    end else if (irq_go || exc_go) begin
      pgie_ff <= gie_ff;
      gie_ff  <= 1'b0;
    end else if (mret_go) begin
      gie_ff  <= pgie_ff;
    end else if (wr_en && PADDR == OFS_STATUS) begin
      gie_ff  <= PWDATA[STATUS_GIE_BIT];
      pgie_ff <= PWDATA[STATUS_PGIE_BIT];
    end
  end

  // ==========================================================
  // per-line enables, reserved lines never enable
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      enable_ff <= RST_ZERO;
    end else if (wr_en && PADDR == OFS_ENABLE) begin
      enable_ff <= PWDATA & IRQ_IMPL_MASK;
    end
  end

  // ==========================================================
  // pending follows the levels; the source owns clearing
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pending_ff <= RST_ZERO;
    end else begin
      pending_ff <= IRQ & IRQ_IMPL_MASK;
    end
  end

  // ==========================================================
  // vector base, return address, cause
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      vector_ff <= RST_ZERO;
    end else if (wr_en && PADDR == OFS_VECTOR) begin
      vector_ff <= {PWDATA[31:VEC_BASE_LSB], 6'h00, PWDATA[1:0]};
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      retaddr_ff <= RST_ZERO;
      cause_ff   <= RST_ZERO;
    end else if (irq_go || exc_go) begin
      retaddr_ff <= PC;
      cause_ff   <= nxt_cause;
    end else begin
      if (wr_en && PADDR == OFS_RETADDR) begin
        retaddr_ff <= {PWDATA[31:1], 1'b0};
      end
      if (wr_en && PADDR == OFS_CAUSE) begin
        cause_ff <= PWDATA;
      end
    end
  end

  // ==========================================================
  // registered outputs toward the fetch unit and the sources
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_ff      <= 1'b0;
      index_ff    <= 5'h00;
      trap_ff     <= 1'b0;
      mret_ff     <= 1'b0;
      tcause_ff   <= RST_ZERO;
      redirect_ff <= RST_ZERO;
    end else begin
      ack_ff  <= irq_go;
      trap_ff <= irq_go || exc_go;
      mret_ff <= mret_go;
      if (irq_go) begin
        index_ff <= pick_idx;
      end
      if (irq_go || exc_go || mret_go) begin
        tcause_ff   <= nxt_cause;
        redirect_ff <= nxt_redirect;
      end
    end
  end

  assign IRQ_ACK               = ack_ff;
  assign TAKEN_INTERRUPT_INDEX = index_ff;
  assign TRAP_TAKEN            = trap_ff;
  assign MRET_TAKEN            = mret_ff;
  assign TRAP_CAUSE            = tcause_ff;
  assign REDIRECT_ADDR         = redirect_ff;

  // ==========================================================
  // checks
  // chosen line is active and no line of higher rank is
  sequence irq_commit_s;
    irq_go && active[pick_idx] &&
    (pick_idx >= 5'(IRQ_CUSTOM_LO) ? (active >> pick_idx) == 32'h00000001
                                   : active[31:16] == 16'h0000) &&
    (pick_idx != 5'(IRQ_SW_IDX) || !active[IRQ_EXT_IDX]) &&
    (pick_idx != 5'(IRQ_TIMER_IDX) ||
     (!active[IRQ_EXT_IDX] && !active[IRQ_SW_IDX]));
  endsequence

  sequence illegal_seen_s;
    INSTR_VALID && !irq_go && cls == CIEU_CLS_ILLEGAL;
  endsequence

  sequence mret_seen_s;
    mret_go;
  endsequence

  ack_pulse_a: assert property (@(posedge MCLK) disable iff (RST)
    IRQ_ACK |=> !IRQ_ACK)
    else $error("acknowledge longer than one cycle");

  ack_commit_a: assert property (@(posedge MCLK) disable iff (RST)
    IRQ_ACK |-> TRAP_TAKEN && TRAP_CAUSE[31] &&
                TRAP_CAUSE[4:0] == TAKEN_INTERRUPT_INDEX)
    else $error("acknowledge without matching trap");

  pick_order_a: assert property (@(posedge MCLK) disable iff (RST)
    irq_go |-> irq_commit_s ##1
      IRQ_ACK && TAKEN_INTERRUPT_INDEX == $past(pick_idx))
    else $error("wrong interrupt index taken");

  gate_enable_a: assert property (@(posedge MCLK) disable iff (RST)
    IRQ_ACK |-> $past(gie_ff) && !$past(DEBUG_MODE) &&
      (($past(active) >> TAKEN_INTERRUPT_INDEX) & 32'h00000001) != RST_ZERO)
    else $error("interrupt taken while disabled");

  debug_ignore_a: assert property (@(posedge MCLK) disable iff (RST)
    DEBUG_MODE |=> !IRQ_ACK)
    else $error("interrupt taken in debug mode");

  entry_save_a: assert property (@(posedge MCLK) disable iff (RST)
    TRAP_TAKEN |-> !gie_ff && pgie_ff == $past(gie_ff) &&
                   retaddr_ff == $past(PC))
    else $error("trap entry state not saved");

  illegal_cause_a: assert property (@(posedge MCLK) disable iff (RST)
    illegal_seen_s |=> TRAP_TAKEN && TRAP_CAUSE == 32'h00000002)
    else $error("illegal instruction not trapped");

  mret_restore_a: assert property (@(posedge MCLK) disable iff (RST)
    mret_seen_s |=> MRET_TAKEN && REDIRECT_ADDR == $past(retaddr_ff) &&
                    gie_ff == $past(pgie_ff))
    else $error("return did not restore state");

  vector_addr_a: assert property (@(posedge MCLK) disable iff (RST)
    IRQ_ACK && vector_ff[1:0] == VEC_MODE_VECTOR |->
      REDIRECT_ADDR == {vector_ff[31:8], 8'h00} +
                       {25'h0000000, TAKEN_INTERRUPT_INDEX, 2'b00})
    else $error("vectored address wrong");

  pending_follow_a: assert property (@(posedge MCLK) disable iff (RST)
    ##1 pending_ff == ($past(IRQ) & IRQ_IMPL_MASK))
    else $error("pending does not follow request lines");

endmodule : cieu_top
`default_nettype wire

// >>> test/cieu_irq_src.sv
// interrupt source model with software and hardware clearing
`timescale 1ns/1ps
`default_nettype none
module cieu_irq_src
  import cieu_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // request control from the bench
  input  wire logic [31:0] raise,
  input  wire logic [31:0] lower,
  input  wire logic        hw_clear,
  // acknowledge from the unit
  input  wire logic        ack,
  input  wire logic [4:0]  ack_index,
  output logic [31:0]      irq
);
  logic [31:0] irq_ff;
  logic [31:0] nxt_irq;
  // ====
  // a line stays up until its source is cleared
  always_comb begin
    nxt_irq = (irq_ff | raise) & ~lower;
    if (hw_clear && ack) begin
      nxt_irq[ack_index] = 1'b0;
    end
  end
  // reserved lines are never driven
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 32'h00000000;
    end else begin
      irq_ff <= nxt_irq & IRQ_IMPL_MASK;
    end
  end
  assign irq = irq_ff;
endmodule : cieu_irq_src
`default_nettype wire

// >>> test/cieu_top_tb_top.sv
// self-checking bench for the interrupt and exception front end
`timescale 1ns/1ps
`default_nettype none
module cieu_top_tb_top;
  import cieu_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, debug_mode = 1'b0, hw_clear = 1'b1;
  logic        instr_valid = 1'b0, prev_ev = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, raise = 32'h0, lower = 32'h0;
  logic [31:0] instr = 32'h0, pc = 32'h00000400;
  logic        pready, pslverr, irq_ack, trap_taken, mret_taken, last_ack;
  logic [4:0]  taken_index, last_idx;
  logic [31:0] prdata, irq, trap_cause, redirect_addr, last_cause, last_rdir;
  logic [31:0] rd;
  int          errors = 0, n_checks = 0, n_ev = 0, long_pulses = 0;
  int          order[4] = '{31, 16, 11, 7};
  logic [31:0] xw[6] = '{32'h0, INSN_ECALL, INSN_EBREAK, 32'h53, 32'hB, 32'h13};
  int          xc[6] = '{2, 11, 3, 2, 2, 0};

  cieu_top #(.FLOAT_UNIT_PRESENT(1'b0), .CUSTOM_EXT_PRESENT(1'b0)) u_cieu_top (
    .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .DEBUG_MODE(debug_mode), .IRQ_ACK(irq_ack),
    .TAKEN_INTERRUPT_INDEX(taken_index), .INSTR_VALID(instr_valid),
    .INSTR(instr), .PC(pc), .TRAP_TAKEN(trap_taken), .MRET_TAKEN(mret_taken),
    .TRAP_CAUSE(trap_cause), .REDIRECT_ADDR(redirect_addr));
  cieu_irq_src u_cieu_irq_src (
    .clk(mclk), .rst(rst), .raise(raise), .lower(lower), .hw_clear(hw_clear),
    .ack(irq_ack), .ack_index(taken_index), .irq(irq));

  always #5 mclk = ~mclk;
  // ====
  // event monitor: pulses must not last two cycles
  always @(posedge mclk) begin
    prev_ev <= trap_taken | mret_taken | irq_ack;
    if ((trap_taken | mret_taken | irq_ack) === 1'b1 && prev_ev === 1'b1) begin
      long_pulses <= long_pulses + 1;
    end
    if ((trap_taken | mret_taken) === 1'b1) begin
      n_ev <= n_ev + 1;
      last_cause <= trap_cause;
      last_rdir <= redirect_addr;
      last_ack <= irq_ack;
      last_idx <= taken_index;
    end
  end
  // ====
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // apb transfer; no wait count assumed
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so a following call never drives psel twice at once
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, e);
  endtask : wr

  task automatic rcheck(input logic [11:0] a, input logic [31:0] exp,
                        input string what);
    apb(1'b0, a, 32'h0, e);
    check(rd, exp, what);
  endtask : rcheck

  // answer comes two edges after its cause, so six cycles covers it
  task automatic expect_ev(input int cnt, input logic [31:0] cause,
                           input logic [31:0] rdir, input logic ack);
    int n0;
    n0 = n_ev;
    repeat (6) @(posedge mclk);
    check(32'(n_ev - n0), 32'(cnt), "event count");
    if (cnt == 1) begin
      check(last_cause, cause, "cause");
      check(last_rdir, rdir, "redirect");
      check({31'h0, last_ack}, {31'h0, ack}, "ack");
      if (ack) begin
        check({27'h0, last_idx}, cause & 32'h1F, "index");
      end
    end
  endtask : expect_ev

  task automatic commit(input logic [31:0] w, input logic [31:0] p);
    instr_valid <= 1'b1;
    instr <= w;
    pc <= p;
    @(posedge mclk);
    instr_valid <= 1'b0;
  endtask : commit

  // ====
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rcheck(OFS_STATUS, 32'h0, "status reset");
    rcheck(OFS_ENABLE, 32'h0, "enable reset");
    apb(1'b0, 12'h0FC, 32'h0, e);
    check({31'h0, e}, 32'h1, "slave error");
    raise <= 32'h80010888;
    @(posedge mclk);
    raise <= 32'h0;
    expect_ev(0, 32'h0, 32'h0, 1'b0);
    rcheck(OFS_PENDING, 32'h80010888, "pending");
    wr(OFS_ENABLE, 32'hFFFFFFF7);
    expect_ev(0, 32'h0, 32'h0, 1'b0);
    rcheck(OFS_ENABLE, 32'hFFFF0880, "enable mask");
    wr(OFS_VECTOR, 32'h00001001);
    foreach (order[i]) begin
      wr(OFS_STATUS, 32'h8);
      expect_ev(1, 32'h80000000 | order[i], 32'(32'h1000 + 4 * order[i]), 1'b1);
      rcheck(OFS_STATUS, 32'h80, "status entry");
    end
    rcheck(OFS_RETADDR, 32'h400, "return pc");
    rcheck(OFS_PENDING, 32'h8, "pending cleared");
    wr(OFS_STATUS, 32'h8);
    expect_ev(0, 32'h0, 32'h0, 1'b0);
    debug_mode <= 1'b1;
    hw_clear <= 1'b0;
    wr(OFS_ENABLE, 32'hFFFFFFFF);
    expect_ev(0, 32'h0, 32'h0, 1'b0);
    wr(OFS_VECTOR, 32'h00002000);
    debug_mode <= 1'b0;
    expect_ev(1, 32'h80000003, 32'h2000, 1'b1);
    rcheck(OFS_PENDING, 32'h8, "level held");
    lower <= 32'h8;
    @(posedge mclk);
    lower <= 32'h0;
    // pending lags the line by one more edge
    @(posedge mclk);
    rcheck(OFS_PENDING, 32'h0, "pending dropped");
    wr(OFS_VECTOR, 32'h00001001);
    foreach (xw[i]) begin
      commit(xw[i], 32'(32'h100 + 4 * i));
      expect_ev(int'(xc[i] != 0), 32'(xc[i]), 32'h1000, 1'b0);
    end
    rcheck(OFS_RETADDR, 32'h110, "exception pc");
    wr(OFS_RETADDR, 32'h3000);
    wr(OFS_STATUS, 32'h80);
    commit(INSN_MRET, 32'h200);
    expect_ev(1, 32'h2, 32'h3000, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0, e);
    check(rd & 32'h8, 32'h8, "enable restored");
    check(32'(long_pulses), 32'h0, "pulse width");
    finish_test();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    finish_test();
  end
endmodule : cieu_top_tb_top
`default_nettype wire
